// ===== rtl/efp_top.sv
`timescale 1ns/100ps
module efp_top #(
    parameter int unsigned GATE_CYC = efp_pkg::GATE_CYC,
    parameter int unsigned STEP_CYC = efp_pkg::STEP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic enc_a_i,
    input wire logic enc_b_i,
    input wire logic pwr_cycle_i,
    output logic irq_o,
    output logic open_fault_o,
    output logic stop_decel_o,
    output logic stop_coast_o,
    output logic dir_fwd_o,
    output logic pulse_o
);
    efp_pkg::efp_act_t act_q, act_d;
    logic dir_sel_q, dir_sel_d, type_pend_q, type_pend_d, type_act_q, type_act_d;
    logic [6:0] open_q, open_d, ticks_q, ticks_d;
    logic [15:0] ppr_q, ppr_d;
    logic [7:0] div_q, div_d;
    logic [9:0] gmot_q, gmot_d, gload_q, gload_d;
    logic [1:0] ist_q, ist_d, imask_q, imask_d;
    logic [31:0] prdata_d, presc_q, presc_d, gate_q, gate_d, speed_q, speed_d;
    logic pready_d, pslverr_d, irq_d, fault_d, decel_d, coast_d;
    logic q_edge, q_arise, q_fwd, dir_prev_q, dir_prev_d, enc_en;
    logic wr, rd, gate_end, div_n;
    logic [5:0] div_k;
    logic [1:0] ev;
    logic [23:0] cnt_q, cnt_d;
    efp_pkg::efp_sp_t sp_q, sp_d;
    logic [39:0] num_q, num_d, quo_q, quo_d;
    logic [40:0] rem_q, rem_d, rem_t;
    logic [25:0] den_q, den_d;
    logic [5:0] bit_q, bit_d;

    // Clamps a write into [lo, hi]; used for the open, ppr and gear settings
    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
    endfunction

    function automatic logic [6:0] dec_div(input logic [7:0] v);
        logic [7:0] k;
        k = (v >= efp_pkg::DIV_N_BASE) ? v - efp_pkg::DIV_N_BASE : v;
        k = (k == 8'h00) ? 8'h01 : ((k > {2'b00, efp_pkg::K_MAX}) ? {2'b00, efp_pkg::K_MAX} : k);
        dec_div = {v >= efp_pkg::DIV_N_BASE, k[5:0]};
    endfunction

    assign {div_n, div_k} = dec_div(div_q);
    assign enc_en = !type_act_q;

    efp_quad u_quad (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .a_i(enc_a_i),
        .b_i(enc_b_i),
        .dir_sel_i(dir_sel_q),
        .en_i(enc_en),
        .edge_o(q_edge),
        .a_rise_o(q_arise),
        .fwd_o(q_fwd)
    );

    efp_pdiv #(.KW(6)) u_pdiv (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .in_i(q_arise),
        .n_i(div_n),
        .k_i(div_k),
        .pulse_o(pulse_o)
    );

    // Register file, APB slave and interrupt logic
    always_comb begin
        wr = psel_i && penable_i && pwrite_i && pready_o;
        rd = psel_i && !penable_i && !pwrite_i;
        act_d = act_q;
        dir_sel_d = dir_sel_q;
        type_pend_d = type_pend_q;
        open_d = open_q;
        ppr_d = ppr_q;
        div_d = div_q;
        gmot_d = gmot_q;
        gload_d = gload_q;
        imask_d = imask_q;
        ist_d = ist_q;
        type_act_d = pwr_cycle_i ? type_pend_q : type_act_q;
        pready_d = psel_i && !penable_i;
        pslverr_d = 1'b0;
        prdata_d = 32'h0;
        if (wr) begin
            case (paddr_i)
                efp_pkg::A_CTRL: begin
                    // Code 3 is out of range; it keeps the drive running
                    act_d = (pwdata_i[1:0] == 2'b00) ? efp_pkg::EFP_DECEL :
                            (pwdata_i[1:0] == 2'b01) ? efp_pkg::EFP_COAST :
                            efp_pkg::EFP_RUN;
                    dir_sel_d = pwdata_i[efp_pkg::CTRL_DIR_BIT];
                    type_pend_d = pwdata_i[efp_pkg::CTRL_TYPE_BIT];
                end
                efp_pkg::A_OPEN: open_d = 7'(clamp16(pwdata_i[15:0], 16'h0000,
                                                    {9'h000, efp_pkg::OPEN_MAX}));
                efp_pkg::A_PPR: ppr_d = clamp16(pwdata_i[15:0], 16'h0000, efp_pkg::PPR_MAX);
                efp_pkg::A_DIV: div_d = pwdata_i[7:0];
                efp_pkg::A_GMOT: gmot_d = 10'(clamp16(pwdata_i[15:0], 16'h0001,
                                                     {6'h00, efp_pkg::GEAR_MAX}));
                efp_pkg::A_GLOAD: gload_d = 10'(clamp16(pwdata_i[15:0], 16'h0001,
                                                       {6'h00, efp_pkg::GEAR_MAX}));
                efp_pkg::A_ISTAT: ist_d = ist_q & ~pwdata_i[1:0];
                efp_pkg::A_IMASK: imask_d = pwdata_i[1:0];
                efp_pkg::A_STAT, efp_pkg::A_SPEED: pslverr_d = 1'b0;
                default: pslverr_d = 1'b0;
            endcase
        end
        if (rd) begin
            case (paddr_i)
                efp_pkg::A_CTRL: prdata_d = {28'h0, type_pend_q, dir_sel_q, act_q};
                efp_pkg::A_OPEN: prdata_d = {25'h0, open_q};
                efp_pkg::A_PPR: prdata_d = {16'h0, ppr_q};
                efp_pkg::A_DIV: prdata_d = {24'h0, div_q};
                efp_pkg::A_GMOT: prdata_d = {22'h0, gmot_q};
                efp_pkg::A_GLOAD: prdata_d = {22'h0, gload_q};
                efp_pkg::A_STAT: prdata_d = {27'h0, stop_coast_o, stop_decel_o, type_act_q,
                                             dir_fwd_o, open_fault_o};
                efp_pkg::A_SPEED: prdata_d = speed_q;
                efp_pkg::A_ISTAT: prdata_d = {30'h0, ist_q};
                efp_pkg::A_IMASK: prdata_d = {30'h0, imask_q};
                default: prdata_d = 32'h0;
            endcase
        end
        if (psel_i && !penable_i) begin
            case (paddr_i)
                efp_pkg::A_CTRL, efp_pkg::A_OPEN, efp_pkg::A_PPR, efp_pkg::A_DIV,
                efp_pkg::A_GMOT, efp_pkg::A_GLOAD, efp_pkg::A_STAT, efp_pkg::A_SPEED,
                efp_pkg::A_ISTAT, efp_pkg::A_IMASK: pslverr_d = 1'b0;
                default: pslverr_d = 1'b1;
            endcase
        end
        // Events are applied after the clear so that a set in the same cycle wins
        ev[efp_pkg::IRQ_OPEN_BIT] = fault_d && !open_fault_o;
        ev[efp_pkg::IRQ_DIR_BIT] = q_edge && (q_fwd != dir_prev_q);
        ist_d = ist_d | ev;
        irq_d = |(ist_d & imask_d);
    end

    // Open-pulse timer, stop action and direction tracking
    always_comb begin
        presc_d = presc_q;
        ticks_d = ticks_q;
        dir_prev_d = q_edge ? q_fwd : dir_prev_q;
        if (q_edge || !enc_en) begin
            presc_d = 32'h0;
            ticks_d = 7'h00;
        end else if (presc_q >= STEP_CYC - 1) begin
            presc_d = 32'h0;
            ticks_d = (ticks_q == 7'h7F) ? ticks_q : ticks_q + 7'h01;
        end else begin
            presc_d = presc_q + 32'h1;
        end
        // Timeout 0.0 s leaves detection off; a fresh edge ends the fault
        fault_d = enc_en && !q_edge && (open_q != 7'h00) &&
                  (open_fault_o || ticks_q >= open_q);
        decel_d = fault_d && (act_q == efp_pkg::EFP_DECEL);
        coast_d = fault_d && (act_q == efp_pkg::EFP_COAST);
    end

    // Speed: phase-A rising edges over a one-second gate, then a serial divide
    always_comb begin
        gate_end = (gate_q >= GATE_CYC - 1);
        gate_d = gate_end ? 32'h0 : gate_q + 32'h1;
        // A pulse on the gate end opens the next count instead of being lost
        cnt_d = gate_end ? {23'h0, q_arise} : (q_arise ? cnt_q + 24'h1 : cnt_q);
        sp_d = sp_q;
        num_d = num_q;
        den_d = den_q;
        quo_d = quo_q;
        rem_d = rem_q;
        bit_d = bit_q;
        speed_d = speed_q;
        rem_t = {rem_q[39:0], num_q[39]};
        case (sp_q)
            efp_pkg::EFP_SP_IDLE: begin
                if (gate_end) begin
                    num_d = 40'(cnt_q * efp_pkg::RPM_MUL * gload_q);
                    den_d = 26'(ppr_q * gmot_q);
                    rem_d = 41'h0;
                    bit_d = 6'h28;
                    sp_d = efp_pkg::EFP_SP_DIV;
                end
            end
            efp_pkg::EFP_SP_DIV: begin
                num_d = {num_q[38:0], 1'b0};
                if (rem_t >= {15'h0, den_q}) begin
                    rem_d = rem_t - {15'h0, den_q};
                    quo_d = {quo_q[38:0], 1'b1};
                end else begin
                    rem_d = rem_t;
                    quo_d = {quo_q[38:0], 1'b0};
                end
                bit_d = bit_q - 6'h01;
                if (bit_q == 6'h01) begin
                    sp_d = efp_pkg::EFP_SP_IDLE;
                    // No ppr means no speed; a huge quotient saturates
                    speed_d = (den_q == 26'h0) ? 32'h0 :
                              ((quo_d[39:32] != 8'h00) ? 32'hFFFFFFFF : quo_d[31:0]);
                end
            end
            default: sp_d = efp_pkg::EFP_SP_IDLE;
        endcase
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            act_q <= efp_pkg::EFP_DECEL;
            dir_sel_q <= 1'b0;
            type_pend_q <= 1'b0;
            type_act_q <= 1'b0;
            open_q <= efp_pkg::OPEN_RST;
            ppr_q <= efp_pkg::PPR_RST;
            div_q <= efp_pkg::DIV_RST;
            gmot_q <= efp_pkg::GEAR_RST;
            gload_q <= efp_pkg::GEAR_RST;
            ist_q <= 2'h0;
            imask_q <= 2'h0;
            prdata_o <= 32'h0;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            irq_o <= 1'b0;
            presc_q <= 32'h0;
            ticks_q <= 7'h00;
            open_fault_o <= 1'b0;
            stop_decel_o <= 1'b0;
            stop_coast_o <= 1'b0;
            dir_prev_q <= 1'b1;
            dir_fwd_o <= 1'b1;
            gate_q <= 32'h0;
            cnt_q <= 24'h0;
            sp_q <= efp_pkg::EFP_SP_IDLE;
            num_q <= 40'h0;
            den_q <= 26'h0;
            quo_q <= 40'h0;
            rem_q <= 41'h0;
            bit_q <= 6'h00;
            speed_q <= 32'h0;
        end else begin
            act_q <= act_d;
            dir_sel_q <= dir_sel_d;
            type_pend_q <= type_pend_d;
            type_act_q <= type_act_d;
            open_q <= open_d;
            ppr_q <= ppr_d;
            div_q <= div_d;
            gmot_q <= gmot_d;
            gload_q <= gload_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            prdata_o <= prdata_d;
            pready_o <= pready_d;
            pslverr_o <= pslverr_d;
            irq_o <= irq_d;
            presc_q <= presc_d;
            ticks_q <= ticks_d;
            open_fault_o <= fault_d;
            stop_decel_o <= decel_d;
            stop_coast_o <= coast_d;
            dir_prev_q <= dir_prev_d;
            dir_fwd_o <= dir_prev_d;
            gate_q <= gate_d;
            cnt_q <= cnt_d;
            sp_q <= sp_d;
            num_q <= num_d;
            den_q <= den_d;
            quo_q <= quo_d;
            rem_q <= rem_d;
            bit_q <= bit_d;
            speed_q <= speed_d;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_fault_after_quiet: assert property (
        $rose(open_fault_o) |-> !$past(q_edge) && $past(ticks_q) >= $past(open_q))
        else $error("open fault raised before timeout");
    a_edge_ends_fault: assert property (
        q_edge |=> !open_fault_o && ticks_q == 7'h00)
        else $error("edge did not restart open timer");
    a_stop_decel_out: assert property (
        (open_fault_o && act_q == efp_pkg::EFP_DECEL && !q_edge) |=> stop_decel_o)
        else $error("decelerate stop missing");
    a_stop_coast_cause: assert property (
        stop_coast_o |-> $past(act_q) == efp_pkg::EFP_COAST && open_fault_o && !stop_decel_o)
        else $error("coast stop without coast action");
    a_type_held: assert property (
        !pwr_cycle_i |=> $stable(type_act_q))
        else $error("encoder type changed without power-up");
    a_div_k_range: assert property (
        div_k >= 6'h01 && div_k <= efp_pkg::K_MAX && (div_n == (div_q >= efp_pkg::DIV_N_BASE)))
        else $error("divider digits out of range");
    a_open_range: assert property (
        open_q <= efp_pkg::OPEN_MAX)
        else $error("open timeout above 10.0 s");
    a_phase_count: assert property (
        (q_arise && !gate_end) |=> cnt_q == $past(cnt_q) + 24'h1)
        else $error("phase A pulse not counted");
    a_speed_no_ppr: assert property (
        (sp_q == efp_pkg::EFP_SP_DIV && bit_q == 6'h01 && den_q == 26'h0) |=> speed_q == 32'h0)
        else $error("speed not zero with zero ppr");
endmodule

// ===== rtl/efp_pkg.sv
package efp_pkg;
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_OPEN = 8'h04;
    localparam logic [7:0] A_PPR = 8'h08;
    localparam logic [7:0] A_DIV = 8'h0C;
    localparam logic [7:0] A_GMOT = 8'h10;
    localparam logic [7:0] A_GLOAD = 8'h14;
    localparam logic [7:0] A_STAT = 8'h18;
    localparam logic [7:0] A_SPEED = 8'h1C;
    localparam logic [7:0] A_ISTAT = 8'h20;
    localparam logic [7:0] A_IMASK = 8'h24;
    localparam int CTRL_ACT_LSB = 0;
    localparam int CTRL_DIR_BIT = 2;
    localparam int CTRL_TYPE_BIT = 3;
    localparam int IRQ_OPEN_BIT = 0;
    localparam int IRQ_DIR_BIT = 1;
    localparam logic [6:0] OPEN_RST = 7'h0A;
    localparam logic [6:0] OPEN_MAX = 7'h64;
    localparam logic [15:0] PPR_RST = 16'h0400;
    localparam logic [15:0] PPR_MAX = 16'hEA60;
    localparam logic [7:0] DIV_RST = 8'h01;
    localparam logic [7:0] DIV_N_BASE = 8'h64;
    localparam logic [5:0] K_MAX = 6'h20;
    localparam logic [9:0] GEAR_RST = 10'h001;
    localparam logic [9:0] GEAR_MAX = 10'h3E8;
    localparam logic [5:0] RPM_MUL = 6'h3C;
    localparam longint CLK_HZ = 125000000;
    localparam longint OPEN_STEP_MS = 100;
    localparam longint GATE_MS = 1000;
    localparam int unsigned STEP_CYC = int'(CLK_HZ * OPEN_STEP_MS / 1000);
    localparam int unsigned GATE_CYC = int'(CLK_HZ * GATE_MS / 1000);
    typedef enum logic [1:0] {
        EFP_DECEL = 2'b00,
        EFP_COAST = 2'b01,
        EFP_RUN = 2'b10
    } efp_act_t;
    typedef enum logic {
        EFP_SP_IDLE = 1'b0,
        EFP_SP_DIV = 1'b1
    } efp_sp_t;
endpackage

// ===== rtl/efp_quad.sv
`timescale 1ns/100ps
module efp_quad (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic a_i,
    input wire logic b_i,
    input wire logic dir_sel_i,
    input wire logic en_i,
    output logic edge_o,
    output logic a_rise_o,
    output logic fwd_o
);
    logic [2:0] a_sq, a_sd, b_sq, b_sd;
    logic edge_d, a_rise_d, fwd_d;
    logic ar, af, br, bf, a_lead, b_lead;
    logic mv_a, mv_b, ok;
    logic [1:0] fill_q, fill_d;

    always_comb begin
        a_sd = {a_sq[1:0], a_i};
        b_sd = {b_sq[1:0], b_i};
        ar = a_sq[1] & ~a_sq[2];
        af = ~a_sq[1] & a_sq[2];
        br = b_sq[1] & ~b_sq[2];
        bf = ~b_sq[1] & b_sq[2];
        mv_a = ar | af;
        mv_b = br | bf;
        // Stages still holding reset zeros are not compared, so a phase high at reset is no edge
        fill_d = (fill_q == 2'h3) ? fill_q : fill_q + 2'h1;
        ok = en_i && (fill_q == 2'h3);
        // Both phases moving at once carries no order, so it is dropped
        // A leads when A moves away from B's level or B moves onto A's level
        a_lead = (mv_a ^ mv_b) & (mv_a ? (a_sq[1] ^ b_sq[1]) : ~(a_sq[1] ^ b_sq[1]));
        b_lead = (mv_a ^ mv_b) & ~a_lead;
        edge_d = ok & (a_lead | b_lead);
        a_rise_d = ok & ar & ~mv_b;
        fwd_d = fwd_o;
        if (edge_d) begin
            fwd_d = a_lead ^ dir_sel_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            a_sq <= 3'h0;
            b_sq <= 3'h0;
            fill_q <= 2'h0;
            edge_o <= 1'b0;
            a_rise_o <= 1'b0;
            fwd_o <= 1'b1;
        end else begin
            a_sq <= a_sd;
            b_sq <= b_sd;
            fill_q <= fill_d;
            edge_o <= edge_d;
            a_rise_o <= a_rise_d;
            fwd_o <= fwd_d;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_dir_phase_order: assert property (
        (en_i && fill_q == 2'h3 && a_sq[1] && !a_sq[2] && !b_sq[1] && !b_sq[2])
        |=> (fwd_o == !$past(dir_sel_i)))
        else $error("phase A lead gave wrong direction");
endmodule

// ===== rtl/efp_pdiv.sv
`timescale 1ns/100ps
module efp_pdiv #(
    parameter int KW = 6
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic in_i,
    input wire logic n_i,
    input wire logic [KW-1:0] k_i,
    output logic pulse_o
);
    logic [KW:0] acc_q, acc_d;
    logic [KW+1:0] sum;
    logic pulse_d;

    always_comb begin
        // Adds 1+n per input pulse and pays out one output per k
        sum = {1'b0, acc_q} + (in_i ? (n_i ? (KW+2)'(2) : (KW+2)'(1)) : '0);
        pulse_d = 1'b0;
        acc_d = sum[KW] ? {1'b0, {KW{1'b1}}} : sum[KW:0];
        // A gap cycle after every pulse keeps pulses countable downstream
        if (!pulse_o && sum >= {2'b00, k_i}) begin
            pulse_d = 1'b1;
            acc_d = (KW+1)'(sum - {2'b00, k_i});
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= '0;
            pulse_o <= 1'b0;
        end else begin
            acc_q <= acc_d;
            pulse_o <= pulse_d;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);

    a_pulse_paid: assert property (
        pulse_o |-> ($past(acc_q) + 2 >= $past(k_i)) && !$past(pulse_o))
        else $error("output pulse without enough credit");
endmodule

// ===== bench/efp_enc_model.sv
`timescale 1ns/100ps
module efp_enc_model (
    input wire logic clk_i,
    input wire logic run_i,
    input wire logic fwd_i,
    input wire logic [7:0] qtr_i,
    output logic a_o,
    output logic b_o
);
    logic [1:0] ph_q = 2'h0;
    logic [7:0] cnt_q = 8'h00;
    // Phases hold still while stopped, as a halted shaft would
    always_ff @(posedge clk_i) begin
        if (run_i) begin
            if (cnt_q >= qtr_i - 8'h01) begin
                cnt_q <= 8'h00;
                ph_q <= fwd_i ? ph_q + 2'h1 : ph_q - 2'h1;
            end else begin
                cnt_q <= cnt_q + 8'h01;
            end
        end
    end
    // Gray steps: forward puts A a quarter period ahead of B
    assign a_o = ph_q[1] ^ ph_q[0];
    assign b_o = ph_q[1];
endmodule

// ===== bench/encoder_feedback_processor_bench.sv
`timescale 1ns/100ps
module encoder_feedback_processor_bench;
    logic clk, rst, psel, penable, pwrite, pwr, run, fwd, ea_d, er;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, irq, fault, sdec, scoa, dfwd, pout, ea, eb;
    int err_count, n_compared, npul, nrise, n, k;
    logic [7:0] ra [9] = '{efp_pkg::A_CTRL, efp_pkg::A_OPEN, efp_pkg::A_PPR, efp_pkg::A_DIV,
        efp_pkg::A_GMOT, efp_pkg::A_GLOAD, efp_pkg::A_STAT, efp_pkg::A_ISTAT, 8'h40};
    logic [31:0] rv [9] = '{32'h0, 32'hA, 32'h400, 32'h1, 32'h1, 32'h1, 32'h2, 32'h0, 32'h0};
    logic [7:0] wa [5] = '{efp_pkg::A_CTRL, efp_pkg::A_OPEN, efp_pkg::A_GLOAD, efp_pkg::A_GMOT,
        efp_pkg::A_DIV};
    logic [31:0] wv [5] = '{32'h3, 32'hC8, 32'h7D0, 32'h0, 32'h84};
    logic [31:0] we [5] = '{32'h2, 32'h64, 32'h3E8, 32'h1, 32'h84};

    efp_top #(.GATE_CYC(1000), .STEP_CYC(100)) uut (.clk_i(clk), .rst_i(rst), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .enc_a_i(ea), .enc_b_i(eb),
        .pwr_cycle_i(pwr), .irq_o(irq), .open_fault_o(fault), .stop_decel_o(sdec),
        .stop_coast_o(scoa), .dir_fwd_o(dfwd), .pulse_o(pout));
    efp_enc_model enc (.clk_i(clk), .run_i(run), .fwd_i(fwd), .qtr_i(8'h0A), .a_o(ea), .b_o(eb));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        if (pout === 1'b1) npul++;
        if (ea === 1'b1 && ea_d === 1'b0) nrise++;
        ea_d <= ea;
    end
    function automatic int exp_pulses(int nn, int kk, int rises);
        return ((1 + nn) * rises) / kk;
    endfunction
    function automatic logic [31:0] exp_rpm(int cnt, int ppr, int load, int mot);
        return 32'(cnt * 60 * load / (ppr * mot));
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic print_verdict();
        if (err_count == 0 && n_compared > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    // Request held until pready is sampled high; one idle cycle between transfers
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && t < 20) begin
            t++;
            @(posedge clk);
        end
        if (t >= 20) err_count++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask

    initial begin
        cyc(40000);
        err_count++;
        print_verdict();
    end

    initial begin
        {rst, psel, penable, pwrite, pwr, run, fwd, ea_d} = 8'h80;
        {paddr, pwdata} = '0;
        {err_count, n_compared, npul, nrise} = '0;
        void'($urandom(32'h0E706F99));
        cyc(2);
        rst <= 1'b0;
        for (int i = 0; i < 9; i++) begin
            apb(1'b0, ra[i], 32'h0);
            check("reset value", rd, rv[i]);
            check("slave error", {31'h0, er}, {31'h0, i == 8});
        end
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, wa[i], wv[i]);
            apb(1'b0, wa[i], 32'h0);
            check("clamped value", rd, we[i]);
        end
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, efp_pkg::A_CTRL, {29'h0, i[1], 2'h0});
            fwd <= i[0];
            run <= 1'b1;
            cyc(100);
            run <= 1'b0;
            check("direction", {31'h0, dfwd}, {31'h0, i[0] ^ i[1]});
        end
        apb(1'b0, efp_pkg::A_ISTAT, 32'h0);
        check("dir event", rd & 32'h2, 32'h2);
        apb(1'b1, efp_pkg::A_OPEN, 32'h3);
        for (int act = 0; act < 3; act++) begin
            apb(1'b1, efp_pkg::A_CTRL, 32'(act));
            run <= 1'b1;
            cyc(600);
            check("fault while moving", {31'h0, fault}, 32'h0);
            run <= 1'b0;
            cyc(200);
            check("fault early", {31'h0, fault}, 32'h0);
            cyc(220);
            check("fault raised", {31'h0, fault}, 32'h1);
            check("decel stop", {31'h0, sdec}, {31'h0, act == 0});
            check("coast stop", {31'h0, scoa}, {31'h0, act == 1});
            if (act == 0) begin
                apb(1'b0, efp_pkg::A_ISTAT, 32'h0);
                check("open event", rd & 32'h1, 32'h1);
                check("masked irq", {31'h0, irq}, 32'h0);
                apb(1'b1, efp_pkg::A_IMASK, 32'h1);
                cyc(3);
                check("irq raised", {31'h0, irq}, 32'h1);
                apb(1'b1, efp_pkg::A_ISTAT, 32'h3);
                cyc(3);
                check("irq cleared", {31'h0, irq}, 32'h0);
            end
        end
        apb(1'b1, efp_pkg::A_OPEN, 32'h0);
        cyc(2);
        check("open detection off", {31'h0, fault}, 32'h0);
        for (int i = 0; i < 7; i++) begin
            n = (i < 3) ? (i / 2) : int'($urandom_range(1, 0));
            k = (i == 0) ? 1 : (i < 3) ? 32 : int'($urandom_range(32, 1));
            do_reset();
            apb(1'b1, efp_pkg::A_DIV, 32'(n * 100 + k));
            npul = 0;
            nrise = 0;
            fwd <= 1'b1;
            run <= 1'b1;
            while (nrise < 64) @(posedge clk);
            run <= 1'b0;
            cyc(20);
            check("divided pulses", 32'(npul), 32'(exp_pulses(n, k, 64)));
        end
        do_reset();
        apb(1'b1, efp_pkg::A_PPR, 32'h5);
        apb(1'b1, efp_pkg::A_GMOT, 32'h2);
        apb(1'b1, efp_pkg::A_GLOAD, 32'h3);
        run <= 1'b1;
        cyc(2600);
        apb(1'b0, efp_pkg::A_SPEED, 32'h0);
        check("speed", rd, exp_rpm(25, 5, 3, 2));
        run <= 1'b0;
        apb(1'b1, efp_pkg::A_CTRL, 32'h8);
        apb(1'b0, efp_pkg::A_STAT, 32'h0);
        check("type before power-up", rd & 32'h4, 32'h0);
        pwr <= 1'b1;
        cyc(1);
        pwr <= 1'b0;
        apb(1'b0, efp_pkg::A_STAT, 32'h0);
        check("type after power-up", rd & 32'h4, 32'h4);
        print_verdict();
    end
endmodule
